// ==== logic/dkr_pkg.sv ====
// constants and types of the disk read task-file command block
package dkr_pkg;
  // task-file register indices on the plain register port
  localparam logic [3:0] REG_DATA = 4'h0; // sector_word_port
  localparam logic [3:0] REG_FAULT = 4'h1; // fault_code rd, feature_select wr
  localparam logic [3:0] REG_LEN = 4'h2; // transfer_length
  localparam logic [3:0] REG_A0 = 4'h3; // address_byte0
  localparam logic [3:0] REG_A1 = 4'h4; // address_byte1
  localparam logic [3:0] REG_A2 = 4'h5; // address_byte2
  localparam logic [3:0] REG_DRV = 4'h6; // drive_and_upper_address
  localparam logic [3:0] REG_OPC = 4'h7; // drive_condition rd, opcode_port wr
  localparam logic [3:0] REG_CTRL = 4'h8; // device control
  localparam logic [3:0] REG_IRQ_STAT = 4'h9; // sticky events, read only
  localparam logic [3:0] REG_IRQ_CLR = 4'hA; // write one to clear
  localparam logic [3:0] REG_IRQ_EN = 4'hB; // event enables
  // opcodes
  localparam logic [7:0] OPC_NATIVE_MAX = 8'h27;
  localparam logic [7:0] OPC_READ_SEC = 8'h20;
  // drive_condition bit positions
  localparam int ST_BUSY = 7;
  localparam int ST_READY = 6;
  localparam int ST_FAULT = 5;
  localparam int ST_SEEK = 4;
  localparam int ST_XFER = 3;
  localparam int ST_CORR = 2;
  localparam int ST_INDEX = 1;
  localparam int ST_ERR = 0;
  // fault_code bit positions
  localparam int ER_UNC = 6;
  localparam int ER_IDNF = 4;
  localparam int ER_ABRT = 2;
  // control and drive/head fields
  localparam int CTRL_HOB = 7;
  localparam int DRV_LBA = 6;
  // interrupt event bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_XFER = 1;
  localparam int IRQ_FAULT = 2;
  localparam int IRQ_W = 3;
  // reset values
  localparam logic [7:0] DRV_RST = 8'hA0;
  localparam logic [7:0] ADDR_RST = 8'h01;
  localparam logic [8:0] LEN_RST = 9'h001;
  localparam logic [8:0] LEN_ZERO_MEANS = 9'h100;
  // register port request
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [3:0]  addr;
    logic [15:0] wdata;
  } dkr_reg_req_t;
  // media fetch request: mode and raw start address
  typedef struct packed {
    logic        valid;
    logic        lba_mode;
    logic [27:0] start;
  } dkr_media_req_t;
  // one data word from the media
  typedef struct packed {
    logic        valid;
    logic [15:0] word;
  } dkr_media_word_t;
  // end of one sector fetch
  typedef struct packed {
    logic done;
    logic uncorrectable_flag;
    logic not_found;
  } dkr_media_end_t;
  // command engine states
  typedef enum logic [1:0] {
    S_IDLE  = 2'b00,
    S_FETCH = 2'b01,
    S_DRQ   = 2'b10,
    S_NEXT  = 2'b11
  } dkr_state_t;
endpackage : dkr_pkg

// ==== logic/dkr_cmd.sv ====
// task-file engine for native max query and sector read
// How it works
// [R1] native max query reports true native limit
// [R2] upper select low: address bits 23:0
// [R3] upper select high: address bits 47:24
// [R4] completion: busy, fault, corrected cleared
// [R5] only abort, uncorrectable, not-found error bits
// [R6] read opcode low bit ignored
// [R7] fetch sector from media, then deliver
// [R8] data moves as 16-bit words
// [R9] uncorrectable error stops read there
// [R10] sector count zero means 256
// [R11] host sets drive/head fixed ones, mode
// [R12] mode zero: cylinder, head, sector start
// [R13] mode one: 28-bit block address start
// [R14] count left holds sectors not moved
// [R15] address left at last transferred sector, or at the failing sector
// [R16] upper select picks high address bytes
// [R17] per sector data request, 256 word reads
`timescale 1ns/1ps
module dkr_cmd #(
  parameter logic [47:0] NATIVE_MAX = 48'h0000_1D1C_5970, // max block
  parameter int          WORDS      = 256,   // words per sector
  parameter logic [7:0]  SPT        = 8'h3F, // sectors per track
  parameter logic [3:0]  HEADS      = 4'hF   // last head number
) (
  input  wire logic                     clk_sys,
  input  wire logic                     reset_n,
  input  wire dkr_pkg::dkr_reg_req_t    reg_req,
  output logic [15:0]                   reg_rdata,
  output dkr_pkg::dkr_media_req_t       media_req,
  input  wire dkr_pkg::dkr_media_word_t media_word,
  output logic                          media_ready,
  input  wire dkr_pkg::dkr_media_end_t  media_end,
  output logic                          irq
);
  import dkr_pkg::*;

  localparam int PW = $clog2(WORDS);
  localparam logic [PW-1:0] LAST = PW'(WORDS - 1);

  // engine state
  dkr_state_t       state;
  // task-file registers
  logic [7:0]       a0;
  logic [7:0]       a1;
  logic [7:0]       a2;
  logic [7:0]       drv;
  logic [8:0]       len_cnt;
  logic [23:0]      hi;        // upper bytes shown under select
  logic             upper_byte_select;       // upper_byte_select
  logic [7:0]       fault_code;
  // sector buffer and pointers
  logic [15:0]      sbuf [WORDS];
  logic [PW-1:0]    wptr;
  logic [PW-1:0]    rptr;
  // interrupt registers
  logic [IRQ_W-1:0] irq_stat;
  logic [IRQ_W-1:0] irq_en;
  logic [IRQ_W-1:0] irq_set;
  // decoded strobes
  logic             busy_flag;
  logic             transfer_request_flag;
  logic             cmd_wr;
  logic             start_read;
  logic             start_nmax;
  logic             start_bad;
  logic             fetch_end;
  logic             fetch_bad;
  logic             host_word;
  logic             sector_out;
  logic             last_sector;
  logic             tf_wr;
  logic [27:0]      cur_addr;
  logic [27:0]      adv_addr;
  logic [7:0]       drive_condition;
  logic [15:0]      next_rdata;

  // step a start address to the following sector
  function automatic logic [27:0] advance(input logic lba,
                                          input logic [27:0] a);
    logic [15:0] cyl;
    logic [3:0]  hd;
    logic [7:0]  sec;
    cyl = a[23:8];
    hd  = a[27:24];
    sec = a[7:0];
    if (lba) begin
      advance = a + 28'h000_0001;
    end else if (sec != SPT) begin
      advance = {hd, cyl, sec + 8'h01};
    end else if (hd != HEADS) begin
      advance = {hd + 4'h1, cyl, 8'h01};
    end else begin
      advance = {4'h0, cyl + 16'h0001, 8'h01};
    end
  endfunction : advance

  // command decode
  assign cmd_wr     = reg_req.wr && (reg_req.addr == REG_OPC)
                      && (state == S_IDLE);
  // [R6] low opcode bit ignored
  assign start_read = cmd_wr
                      && (reg_req.wdata[7:1] == OPC_READ_SEC[7:1]);
  assign start_nmax = cmd_wr
                      && (reg_req.wdata[7:0] == OPC_NATIVE_MAX);
  assign start_bad  = cmd_wr && !start_read && !start_nmax;
  // count and address register writes while idle only
  assign tf_wr      = reg_req.wr && (state == S_IDLE);

  // engine flags
  // [R4] busy while fetching or stepping
  assign busy_flag             = (state == S_FETCH) || (state == S_NEXT);
  assign transfer_request_flag = (state == S_DRQ);
  assign fetch_end   = (state == S_FETCH) && media_end.done;
  assign fetch_bad   = fetch_end && (media_end.uncorrectable_flag || media_end.not_found);
  // [R8] one data register read moves one word
  assign host_word   = transfer_request_flag && reg_req.rd
                       && (reg_req.addr == REG_DATA);
  // sector boundary on its last word read
  assign sector_out  = host_word && (rptr == LAST);
  assign last_sector = (len_cnt == 9'h001);
  assign cur_addr    = {drv[3:0], a2, a1, a0};
  assign adv_addr    = advance(drv[DRV_LBA], cur_addr);

  // command engine sequencing
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      state <= S_IDLE;
    end else begin
      case (state)
        S_IDLE: begin
          // [R7] read starts with a media fetch
          if (start_read) begin
            state <= S_FETCH;
          end
        end
        S_FETCH: begin
          // [R9] failing sector ends the read
          if (fetch_bad) begin
            state <= S_IDLE;
          end else if (fetch_end) begin
            state <= S_DRQ;
          end
        end
        S_DRQ: begin
          // [R17] wait for all words of this sector
          if (sector_out) begin
            state <= last_sector ? S_IDLE : S_NEXT;
          end
        end
        default: begin
          // step address, then fetch again
          state <= S_FETCH;
        end
      endcase
    end
  end

  // media request pulse, one cycle after start or step
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      media_req <= '0;
    end else begin
      media_req.valid    <= start_read || (state == S_NEXT);
      media_req.lba_mode <= drv[DRV_LBA];
      // [R7] a step fetches the advanced address, not the old one
      if (state == S_NEXT) begin
        media_req.start <= adv_addr;
      end else begin
        media_req.start <= cur_addr;
      end
    end
  end

  // media words are taken only while fetching
  assign media_ready = (state == S_FETCH);

  // sector buffer fill from media
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wptr <= '0;
    end else if (state != S_FETCH) begin
      wptr <= '0;
    end else if (media_word.valid) begin
      wptr <= wptr + PW'(1);
    end
  end

  // buffer storage, no reset needed
  always_ff @(posedge clk_sys) begin
    if (media_ready && media_word.valid) begin
      sbuf[wptr] <= media_word.word;
    end
  end

  // host read pointer
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      rptr <= '0;
    end else if (state != S_DRQ) begin
      rptr <= '0;
    end else if (host_word) begin
      rptr <= rptr + PW'(1);
    end
  end

  // task-file address and count registers
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      a0      <= ADDR_RST;
      a1      <= '0;
      a2      <= '0;
      drv     <= DRV_RST;
      len_cnt <= LEN_RST;
      hi      <= '0;
    end else if (start_nmax) begin
      // [R1] fixed native limit, never the set-max value
      // [R2] low three bytes in the address registers
      {a2, a1, a0} <= NATIVE_MAX[23:0];
      // [R3] upper three bytes shown under select
      hi <= NATIVE_MAX[47:24];
    end else if (start_read) begin
      // [R10] zero count asks for 256 sectors
      if (len_cnt[7:0] == 8'h00) begin
        len_cnt <= LEN_ZERO_MEANS;
      end
    end else if (state == S_NEXT) begin
      // [R15] address steps after each delivered sector except the last
      {drv[3:0], a2, a1, a0} <= adv_addr;
    end else if (sector_out) begin
      // [R14] count drops only for moved sectors
      len_cnt <= len_cnt - 9'h001;
    end else if (tf_wr) begin
      // [R11] [R12] [R13] host loads start address
      if (reg_req.addr == REG_LEN) begin
        // requested sector count
        len_cnt <= {1'b0, reg_req.wdata[7:0]};
      end else if (reg_req.addr == REG_A0) begin
        // sector number or block bits 7:0
        a0 <= reg_req.wdata[7:0];
      end else if (reg_req.addr == REG_A1) begin
        // cylinder low or block bits 15:8
        a1 <= reg_req.wdata[7:0];
      end else if (reg_req.addr == REG_A2) begin
        // cylinder high or block bits 23:16
        a2 <= reg_req.wdata[7:0];
      end else if (reg_req.addr == REG_DRV) begin
        // mode, drive and head or block bits 27:24
        drv <= reg_req.wdata[7:0];
      end
    end
  end

  // upper byte select in the control register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      upper_byte_select <= 1'b0;
    end else if (reg_req.wr && (reg_req.addr == REG_CTRL)) begin
      // [R16] host picks upper or lower bytes
      upper_byte_select <= reg_req.wdata[CTRL_HOB];
    end else if (tf_wr && (reg_req.addr >= REG_LEN)
                 && (reg_req.addr <= REG_DRV)) begin
      // address writes fall back to lower bytes
      upper_byte_select <= 1'b0;
    end
  end

  // error register
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      fault_code <= '0;
    end else if (cmd_wr) begin
      // [R5] new command starts clean, abort if unknown
      fault_code <= '0;
      fault_code[ER_ABRT] <= start_bad;
    end else if (fetch_bad) begin
      // [R5] read may add uncorrectable and not-found
      fault_code[ER_UNC]  <= media_end.uncorrectable_flag;
      fault_code[ER_IDNF] <= media_end.not_found;
    end
  end

  // status byte
  // [R4] fault and corrected stay clear, error is summary
  always_comb begin
    drive_condition           = '0;
    drive_condition[ST_BUSY]  = busy_flag;
    drive_condition[ST_READY] = 1'b1;
    drive_condition[ST_FAULT] = 1'b0;
    drive_condition[ST_SEEK]  = 1'b1;
    drive_condition[ST_XFER]  = transfer_request_flag;
    drive_condition[ST_CORR]  = 1'b0;
    drive_condition[ST_INDEX] = 1'b0;
    drive_condition[ST_ERR]   = |fault_code;
  end

  // interrupt events
  always_comb begin
    irq_set            = '0;
    irq_set[IRQ_DONE]  = start_nmax || start_bad || fetch_bad
                         || (sector_out && last_sector);
    irq_set[IRQ_XFER]  = fetch_end && !fetch_bad;
    irq_set[IRQ_FAULT] = start_bad || fetch_bad;
  end

  // sticky status: a new event beats a same-cycle clear
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_stat <= '0;
    end else if (reg_req.wr && (reg_req.addr == REG_IRQ_CLR)) begin
      irq_stat <= (irq_stat & ~reg_req.wdata[IRQ_W-1:0]) | irq_set;
    end else begin
      irq_stat <= irq_stat | irq_set;
    end
  end

  // interrupt enables
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      irq_en <= '0;
    end else if (reg_req.wr && (reg_req.addr == REG_IRQ_EN)) begin
      irq_en <= reg_req.wdata[IRQ_W-1:0];
    end
  end

  // level interrupt
  assign irq = |(irq_stat & irq_en);

  // read data selection
  always_comb begin
    next_rdata = '0;
    if (reg_req.addr == REG_DATA) begin
      // [R8] word from the sector buffer
      next_rdata = transfer_request_flag ? sbuf[rptr] : 16'h0000;
    end else if (reg_req.addr == REG_FAULT) begin
      // error bits of the last command
      next_rdata[7:0] = fault_code;
    end else if (reg_req.addr == REG_LEN) begin
      // count left, no upper byte kept
      next_rdata[7:0] = upper_byte_select ? 8'h00 : len_cnt[7:0];
    end else if (reg_req.addr == REG_A0) begin
      // [R2] [R3] byte chosen by upper select
      next_rdata[7:0] = upper_byte_select ? hi[7:0] : a0;
    end else if (reg_req.addr == REG_A1) begin
      next_rdata[7:0] = upper_byte_select ? hi[15:8] : a1;
    end else if (reg_req.addr == REG_A2) begin
      next_rdata[7:0] = upper_byte_select ? hi[23:16] : a2;
    end else if (reg_req.addr == REG_DRV) begin
      // mode, drive and head nibble
      next_rdata[7:0] = drv;
    end else if (reg_req.addr == REG_OPC) begin
      // status byte on the command index
      next_rdata[7:0] = drive_condition;
    end else if (reg_req.addr == REG_CTRL) begin
      // upper select read back
      next_rdata[CTRL_HOB] = upper_byte_select;
    end else if (reg_req.addr == REG_IRQ_STAT) begin
      // sticky event bits
      next_rdata[IRQ_W-1:0] = irq_stat;
    end else if (reg_req.addr == REG_IRQ_EN) begin
      // event enables read back
      next_rdata[IRQ_W-1:0] = irq_en;
    end
  end

  // read data one cycle after the strobe, zero otherwise
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= '0;
    end else if (reg_req.rd) begin
      reg_rdata <= next_rdata;
    end else begin
      reg_rdata <= '0;
    end
  end
endmodule : dkr_cmd

// ==== test/dkr_cmd_checker.sv ====
// port-level properties of the disk read command block
`timescale 1ns/1ps
module dkr_cmd_checker (
  input wire logic                     clk_sys,
  input wire logic                     reset_n,
  input wire dkr_pkg::dkr_reg_req_t    reg_req,
  input wire logic [15:0]              reg_rdata,
  input wire dkr_pkg::dkr_media_req_t  media_req,
  input wire logic                     media_ready,
  input wire dkr_pkg::dkr_media_end_t  media_end
);
  import dkr_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  logic st_rd; // status read launched
  logic er_rd; // error read launched
  logic bad;   // failing fetch end
  assign st_rd = reg_req.rd && reg_req.addr == REG_OPC;
  assign er_rd = reg_req.rd && reg_req.addr == REG_FAULT;
  assign bad = media_ready && media_end.done && (media_end.uncorrectable_flag || media_end.not_found);
  chk_rdata_idle: assert property (!reg_req.rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  chk_req_pulse: assert property (media_req.valid |=> !media_req.valid)
    else $error("fetch request longer than one cycle");
  chk_req_ready: assert property (media_req.valid |-> media_ready)
    else $error("fetch request without fetch window");
  chk_busy_fetch: assert property (st_rd && media_ready |=> reg_rdata[ST_BUSY])
    else $error("status not busy while fetching");
  chk_status_fixed: assert property (st_rd |=> reg_rdata[ST_READY]
    && !reg_rdata[ST_FAULT] && !reg_rdata[ST_CORR] && reg_rdata[15:8] == 8'h00)
    else $error("status fixed bits wrong");
  chk_xfer_nobusy: assert property (st_rd |=>
    !(reg_rdata[ST_BUSY] && reg_rdata[ST_XFER]))
    else $error("data request shown with busy");
  chk_fault_bits: assert property (er_rd |=> reg_rdata[7] == 1'b0
    && reg_rdata[5] == 1'b0 && reg_rdata[3] == 1'b0 && reg_rdata[1:0] == 2'b00)
    else $error("error register reserved bit set");
  chk_data_fetch: assert property (reg_req.rd && reg_req.addr == REG_DATA
    && media_ready |=> reg_rdata == 16'h0000)
    else $error("data word returned before data request");
  chk_end_leave: assert property (media_ready && media_end.done |=> !media_ready)
    else $error("fetch window stays after fetch end");
  chk_fail_stop: assert property (bad |=> (!media_ready && !media_req.valid) [*8])
    else $error("read goes on after failing sector");
  cov_fetch: cover property (media_req.valid);
  cov_fail: cover property (bad);
  cov_xfer: cover property (st_rd ##1 reg_rdata[ST_XFER]);
endmodule : dkr_cmd_checker
bind dkr_cmd dkr_cmd_checker i_dkr_cmd_checker (.clk_sys(clk_sys), .reset_n(reset_n),
  .reg_req(reg_req), .reg_rdata(reg_rdata), .media_req(media_req),
  .media_ready(media_ready), .media_end(media_end));

// ==== test/dkr_media_model.sv ====
// media side model: streams sector words and reports each fetch end
`timescale 1ns/1ps
module dkr_media_model #(
  parameter int WORDS = 256 // words per sector
) (
  input  wire logic                     clk_sys,
  input  wire logic                     reset_n,
  input  wire dkr_pkg::dkr_media_req_t  media_req,
  input  wire logic                     media_ready,
  input  wire logic [27:0]              bad_start,
  input  wire logic                     bad_nf,
  output dkr_pkg::dkr_media_word_t      media_word,
  output dkr_pkg::dkr_media_end_t       media_end
);
  import dkr_pkg::*;
  logic        active; // fetch in progress
  logic        phase;  // pacing toggle for slow sectors
  logic [27:0] start;  // sector being fetched
  int          n;      // words sent so far
  logic        hit;    // this sector fails
  assign hit = start == bad_start;
  // fetch engine: odd sectors answer every other cycle
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      active <= 1'b0;
      phase <= 1'b0;
      start <= '0;
      n <= 0;
      media_word <= '0;
      media_end <= '0;
    end else begin
      phase <= ~phase;
      media_end <= '0;
      // released data line shows the inverse of its last value
      media_word <= '{valid: 1'b0, word: ~media_word.word};
      if (media_req.valid) begin
        active <= 1'b1;
        start <= media_req.start;
        n <= 0;
      end else if (active && media_ready) begin
        if (n == WORDS) begin
          media_end <= '{done: 1'b1, uncorrectable_flag: hit && !bad_nf, not_found: hit && bad_nf};
          active <= 1'b0;
        end else if (!start[0] || phase) begin
          // one 16-bit word tagged with sector and index
          media_word <= '{valid: 1'b1, word: {start[7:0], 8'(n)}};
          n <= n + 1;
        end
      end
    end
  end
endmodule : dkr_media_model

// ==== test/tb_disk_read_task_file_cmds.sv ====
// register-level testbench of the disk read command block
`timescale 1ns/1ps
module tb_disk_read_task_file_cmds;
  import dkr_pkg::*;
  localparam int W = 4; // short sectors
  logic            clk_sys, reset_n, irq, media_ready, bad_nf;
  dkr_reg_req_t    req;
  logic [15:0]     rdata, v;
  dkr_media_req_t  mreq;
  dkr_media_word_t mword;
  dkr_media_end_t  mend;
  logic [27:0]     bad_start, last_start;
  int              bad_count, n_checks;
  dkr_cmd #(.NATIVE_MAX(48'hABCD_1D1C_5970), .WORDS(W)) i_dkr_cmd (.clk_sys(clk_sys),
    .reset_n(reset_n), .reg_req(req), .reg_rdata(rdata), .media_req(mreq),
    .media_word(mword), .media_ready(media_ready), .media_end(mend), .irq(irq));
  dkr_media_model #(.WORDS(W)) i_dkr_media_model (.clk_sys(clk_sys), .reset_n(reset_n),
    .media_req(mreq), .media_ready(media_ready), .bad_start(bad_start), .bad_nf(bad_nf),
    .media_word(mword), .media_end(mend));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // remember the last fetched start address
  always @(posedge clk_sys) if (mreq.valid) last_start <= mreq.start;
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    req.wr <= 1'b1; req.addr <= a; req.wdata <= d;
    @(posedge clk_sys); req.wr <= 1'b0;
    @(posedge clk_sys);
  endtask : wr
  task automatic rd(input logic [3:0] a);
    req.rd <= 1'b1; req.addr <= a;
    @(posedge clk_sys); req.rd <= 1'b0;
    #1 v = rdata;
    @(posedge clk_sys);
  endtask : rd
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic rc(input logic [3:0] a, input logic [15:0] e, input string nm);
    rd(a); chk(nm, v, e);
  endtask : rc
  // poll status until a bit reaches a level
  task automatic poll(input int b, input logic lvl);
    for (int i = 0; i < 100; i++) begin
      rd(REG_OPC);
      if (v[b] === lvl) break;
    end
  endtask : poll
  task automatic setup(input logic [7:0] drv, a0, a1, a2, len);
    wr(REG_DRV, {8'h00, drv}); wr(REG_A0, {8'h00, a0}); wr(REG_A1, {8'h00, a1});
    wr(REG_A2, {8'h00, a2}); wr(REG_LEN, {8'h00, len});
  endtask : setup
  // one sector of words, high byte names the sector
  task automatic sec(input logic [7:0] hi);
    poll(ST_XFER, 1'b1);
    for (int i = 0; i < W; i++) begin
      rd(REG_DATA); chk("word", v, {hi, 8'(i)});
    end
  endtask : sec
  task automatic finish_test;
    $display("checks %0d errors %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : finish_test
  initial begin
    repeat (60000) @(posedge clk_sys);
    bad_count++;
    finish_test;
  end
  initial begin
    req = '0; reset_n = 1'b0; bad_start = '1; bad_nf = 1'b0;
    bad_count = 0; n_checks = 0;
    repeat (12) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    // reset values and an unmapped index
    rc(REG_A0, 16'h0001, "a0"); rc(REG_DRV, 16'h00A0, "drv");
    rc(REG_OPC, 16'h0050, "status");
    rc(4'hC, 16'h0000, "unmapped");
    // native max in both byte halves, done interrupt
    wr(REG_IRQ_EN, 16'h0001); wr(REG_OPC, 16'h0027);
    rc(REG_A0, 16'h0070, "max0"); rc(REG_A1, 16'h0059, "max1");
    rc(REG_A2, 16'h001C, "max2");
    wr(REG_CTRL, 16'h0080); rc(REG_CTRL, 16'h0080, "select");
    rc(REG_A0, 16'h001D, "max3"); rc(REG_A1, 16'h00CD, "max4");
    rc(REG_A2, 16'h00AB, "max5");
    rc(REG_FAULT, 16'h0000, "err");
    chk("irq", 16'(irq), 16'h0001); wr(REG_IRQ_CLR, 16'h0007); chk("irq", 16'(irq), 16'h0000);
    // block-address reads under both opcodes
    for (int k = 0; k < 2; k++) begin
      setup(8'hE0, 8'h10 + 8'(2 * k), 8'h00, 8'h00, 8'h02);
      wr(REG_OPC, 16'h0020 + 16'(k));
      sec(8'h10 + 8'(2 * k)); sec(8'h11 + 8'(2 * k));
      rc(REG_LEN, 16'h0000, "left");
      rc(REG_A0, 16'h0011 + 16'(2 * k), "last");
      chk("start", 16'(last_start), 16'h0011 + 16'(2 * k));
    end
    // cylinder/head/sector read across a track end, data port idle while fetching
    setup(8'hA0, 8'h3F, 8'h05, 8'h00, 8'h02); wr(REG_OPC, 16'h0020);
    rc(REG_DATA, 16'h0000, "early");
    sec(8'h3F); sec(8'h01);
    rc(REG_A0, 16'h0001, "sect"); rc(REG_DRV, 16'h00A1, "head");
    chk("chs", 16'(last_start), 16'h0501);
    // uncorrectable, then not found, on the second sector
    bad_start <= 28'h000_0021;
    for (int k = 0; k < 2; k++) begin
      bad_nf <= k[0];
      setup(8'hE0, 8'h20, 8'h00, 8'h00, 8'h03); wr(REG_OPC, 16'h0020); sec(8'h20);
      poll(ST_BUSY, 1'b0); chk("status", v, 16'h0051);
      rc(REG_FAULT, k ? 16'h0010 : 16'h0040, "err");
      rc(REG_LEN, 16'h0002, "left");
      rc(REG_A0, 16'h0021, "fail");
      chk("stop", 16'(last_start), 16'h0021);
      rc(REG_IRQ_STAT, 16'h0007, "events"); wr(REG_IRQ_CLR, 16'h0007);
    end
    bad_start <= '1;
    // zero count moves 256 sectors
    setup(8'hE0, 8'h00, 8'h01, 8'h00, 8'h00); wr(REG_OPC, 16'h0021);
    for (int s = 0; s < 256; s++) sec(8'(s));
    rc(REG_LEN, 16'h0000, "left"); rc(REG_A0, 16'h00FF, "last");
    rc(REG_A1, 16'h0001, "last1");
    // refused opcode, interrupt masked then enabled
    wr(REG_IRQ_EN, 16'h0000); wr(REG_OPC, 16'h0055);
    rc(REG_FAULT, 16'h0004, "abort");
    chk("masked", 16'(irq), 16'h0000); wr(REG_IRQ_EN, 16'h0004);
    chk("raised", 16'(irq), 16'h0001); wr(REG_IRQ_CLR, 16'h0007);
    chk("cleared", 16'(irq), 16'h0000);
    finish_test;
  end
endmodule : tb_disk_read_task_file_cmds
